// File: src/timing_cfg_defines.vh
`ifndef TIMING_CFG_DEFINES_VH
`define TIMING_CFG_DEFINES_VH

// ----------------------------------------
// register word offsets (compared with adr_i bits 5 to 2)
// ----------------------------------------
`define OFS_MEM_CFG2 4'h0
`define OFS_MEM_CFG3 4'h1
`define OFS_PHYUPD_RESP 4'h2
`define OFS_RDEN_DELAY 4'h3
`define OFS_RD_GAP 4'h4
`define OFS_CTRL 4'h5
`define OFS_STATUS 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG2_CKE_INIT_BIT 0
`define CFG2_DQM_INIT_BIT 1
`define CFG2_CLKCFG_LSB 2
`define CFG3_PRESCALE_LSB 3
`define CFG3_PRESCALE_MSB 12

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define CFG3_RESET 13'h0009
`define PHYUPD_RESET 8'h00
`define RDEN_RESET 4'h2
`define RD_GAP_RESET 2'h1
`define CLK_ASYNC 2'h0
`define CLK_SYNC_SLOW 2'h1
`define CLK_SYNC_FAST 2'h3
`define RESP_SREF_STALL 2'h0
`define RESP_STALL 2'h1

// ----------------------------------------
// controller states
// ----------------------------------------
`define ST_SETUP 2'h0
`define ST_RUN 2'h1
`define ST_SLEEP 2'h2

`endif

// File: src/strap_sync.v
`timescale 1ns/10ps
// three flip-flop pin synchroniser, change accepted when stages two and three agree
module strap_sync (
    input wire clk_i,
    input wire rst_i,
    input wire pin_i,
    output reg level_o
);
    reg s1;
    reg s2;
    reg s3;

    // chain keeps shifting through reset so the strap is settled at release
    always @(posedge clk_i) begin
        s1 <= pin_i;
        s2 <= s1;
        s3 <= s2;
        if (rst_i || s2 == s3) begin
            level_o <= s3; // follows the pin in reset, filtered after
        end
    end
endmodule // strap_sync

// File: src/rden_delay.v
`timescale 1ns/10ps
`include "timing_cfg_defines.vh"
// counts the programmed delay after a read command, then raises the enable
module rden_delay (
    input wire clk_i,
    input wire rst_i,
    input wire rd_cmd_i,
    input wire [3:0] delay_i,
    output reg rden_o
);
    reg [15:0] pipe;

    // one tap per cycle of delay; tap n fires n+1 cycles after the command
    always @(posedge clk_i) begin
        if (rst_i) begin
            pipe <= 16'h0000;
            rden_o <= 1'b0;
        end else begin
            pipe <= {pipe[14:0], rd_cmd_i};
            if (delay_i == 4'h0) begin
                rden_o <= rd_cmd_i;
            end else begin
                rden_o <= pipe[delay_i - 4'h1];
            end
        end
    end
endmodule // rden_delay

// File: src/dram_ctrl_timing_config_regs.v
`timescale 1ns/10ps
`include "timing_cfg_defines.vh"
// Function
// - with the legacy pads, clock-enable and data-mask outputs take their init bits at memory reset release; with DFI pads the bits are reserved.
// - the clocking scheme field loads its default from the two clock straps at bus reset release.
// - clocking scheme b00 is asynchronous, b01 synchronous bus not faster, b11 synchronous bus faster, b10 reserved.
// - a 10-bit self-refresh prescaler sits at bits 12 to 3 of the third config register and takes any value 0 to 1023.
// - a 3-bit field at bits 2 to 0 limits outstanding refreshes and software writes only 1 to 7.
// - update response, read enable delay and read gap registers are reachable only in setup or sleep state.
// - update response and read enable delay exist only with DFI pads; the read gap always exists.
// - four 2-bit selectors at bits 1:0, 3:2, 5:4, 7:6 pick the answer to update types 00, 01, 10, 11.
// - selector b00 enters self-refresh then stalls the DFI, b01 only stalls, b10 and b11 are reserved.
// - after a read command the read data enable rises after the programmed 4-bit delay in memory clocks.
// - back-to-back reads to different devices get a gap of b01 one idle cycle (default) or b10 two.
// - unused upper bits read undefined (here zero) and software writes them as zero.
module dram_ctrl_timing_config_regs #(
    parameter DFI_PADS = 1
) (
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:2] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o,
    // straps and resets
    input wire same_clock_strap_i,
    input wire bus_faster_strap_i,
    input wire cke_init_strap_i,
    input wire dqm_init_strap_i,
    input wire mem_reset_release_i,
    // command side
    input wire rd_cmd_i,
    input wire rd_other_device_i,
    input wire phyupd_req_i,
    input wire [1:0] phyupd_type_i,
    input wire sref_done_i,
    output reg dfi_rddata_en_o,
    output reg rd_hold_o,
    output reg phyupd_ack_o,
    output reg dfi_stall_o,
    output reg sref_req_o,
    output reg cke_o,
    output reg dqm_o,
    output reg [1:0] clock_cfg_o,
    output reg [9:0] prescale_o,
    output reg [2:0] max_refs_o
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg cke_init;
    reg dqm_init;
    reg [1:0] clock_cfg;
    reg [12:0] cfg3;
    reg [7:0] phyupd_resp;
    reg [3:0] rden_delay_val;
    reg [1:0] rd_gap;
    reg [1:0] ctrl_state;
    reg strap_load;
    reg [1:0] upd_state;
    reg [1:0] gap_cnt;
    reg last_was_read;
    wire same_clk_sync;
    wire fast_sync;
    wire cke_sync;
    wire dqm_sync;
    wire rden;
    wire wr;
    wire rd;
    wire cfg_open;
    wire [1:0] upd_sel;
    wire [31:0] cfg3_new;

    localparam UPD_IDLE = 2'h0;
    localparam UPD_SREF = 2'h1;
    localparam UPD_STALL = 2'h2;
    localparam UPD_EXIT = 2'h3;

    // strap pins come from outside the clock domain
    strap_sync u_same (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(same_clock_strap_i),
        .level_o(same_clk_sync)
    );
    strap_sync u_fast (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(bus_faster_strap_i),
        .level_o(fast_sync)
    );
    strap_sync u_cke (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(cke_init_strap_i),
        .level_o(cke_sync)
    );
    strap_sync u_dqm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(dqm_init_strap_i),
        .level_o(dqm_sync)
    );

    rden_delay u_rden (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rd_cmd_i(rd_cmd_i),
        .delay_i(rden_delay_val),
        .rden_o(rden)
    );

    // byte-lane merge for writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // true for registers present in this build
    function present;
        input [3:0] a;
        begin
            case (a)
                `OFS_MEM_CFG2, `OFS_MEM_CFG3, `OFS_RD_GAP, `OFS_CTRL, `OFS_STATUS: present = 1'b1;
                `OFS_PHYUPD_RESP, `OFS_RDEN_DELAY: present = (DFI_PADS != 0);
                default: present = 1'b0;
            endcase
        end
    endfunction

    assign wr = cyc_i & stb_i & we_i & ~ack_o & ~err_o;
    assign rd = cyc_i & stb_i & ~we_i & ~ack_o & ~err_o;
    assign cfg_open = (ctrl_state == `ST_SETUP) || (ctrl_state == `ST_SLEEP);
    // byte-lane merged write value for config three
    assign cfg3_new = merge({19'h00000, cfg3}, dat_i, sel_i);

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    // single-cycle ack, err for absent offsets
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= (wr | rd) & present(adr_i);
            err_o <= (wr | rd) & ~present(adr_i);
            dat_o <= 32'h00000000; // unused bits read zero
            if (rd) begin
                case (adr_i)
                    `OFS_MEM_CFG2: dat_o <= {28'h0000000, clock_cfg, dqm_init, cke_init};
                    `OFS_MEM_CFG3: dat_o <= {19'h00000, cfg3};
                    `OFS_PHYUPD_RESP: dat_o <= cfg_open ? {24'h000000, phyupd_resp} : 32'h0;
                    `OFS_RDEN_DELAY: dat_o <= cfg_open ? {28'h0000000, rden_delay_val} : 32'h0;
                    `OFS_RD_GAP: dat_o <= cfg_open ? {30'h00000000, rd_gap} : 32'h0;
                    `OFS_CTRL: dat_o <= {30'h00000000, ctrl_state};
                    `OFS_STATUS: dat_o <= {29'h0, dfi_stall_o, sref_req_o, phyupd_ack_o};
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // configuration registers, straps caught one cycle after reset release
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_load <= 1'b1;
            cke_init <= 1'b0;
            dqm_init <= 1'b0;
            clock_cfg <= `CLK_ASYNC;
            cfg3 <= `CFG3_RESET;
            phyupd_resp <= `PHYUPD_RESET;
            rden_delay_val <= `RDEN_RESET;
            rd_gap <= `RD_GAP_RESET;
            ctrl_state <= `ST_SETUP;
        end else begin
            strap_load <= 1'b0;
            if (strap_load) begin
                clock_cfg <= {fast_sync & same_clk_sync, same_clk_sync};
                cke_init <= cke_sync;
                dqm_init <= dqm_sync;
            end else if (wr) begin
                if (adr_i == `OFS_CTRL && sel_i[0] && dat_i[1:0] != 2'h3) begin
                    ctrl_state <= dat_i[1:0];
                end
                if (cfg_open) begin
                    case (adr_i)
                        `OFS_MEM_CFG2: begin
                            if (sel_i[0]) begin
                                cke_init <= dat_i[`CFG2_CKE_INIT_BIT];
                                dqm_init <= dat_i[`CFG2_DQM_INIT_BIT];
                                if (dat_i[3:2] != 2'h2) begin // reserved code ignored
                                    clock_cfg <= dat_i[3:2];
                                end
                            end
                        end
                        `OFS_MEM_CFG3: cfg3 <= cfg3_new[12:0];
                        `OFS_PHYUPD_RESP: if (sel_i[0]) phyupd_resp <= dat_i[7:0];
                        `OFS_RDEN_DELAY: if (sel_i[0]) rden_delay_val <= dat_i[3:0];
                        `OFS_RD_GAP: if (sel_i[0]) rd_gap <= dat_i[1:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // pad levels and field outputs
    // ----------------------------------------
    // init levels applied when memory reset releases (legacy pads only)
    always @(posedge clk_i) begin
        if (rst_i) begin
            cke_o <= 1'b0;
            dqm_o <= 1'b0;
            clock_cfg_o <= `CLK_ASYNC;
            prescale_o <= 10'h000;
            max_refs_o <= 3'h1;
        end else begin
            if (mem_reset_release_i && DFI_PADS == 0) begin
                cke_o <= cke_init;
                dqm_o <= dqm_init;
            end
            clock_cfg_o <= clock_cfg;
            prescale_o <= cfg3[`CFG3_PRESCALE_MSB:`CFG3_PRESCALE_LSB];
            max_refs_o <= cfg3[2:0];
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // rddata enable and inter-device read gap
    always @(posedge clk_i) begin
        if (rst_i) begin
            dfi_rddata_en_o <= 1'b0;
            rd_hold_o <= 1'b0;
            gap_cnt <= 2'h0;
            last_was_read <= 1'b0;
        end else begin
            dfi_rddata_en_o <= rden;
            last_was_read <= rd_cmd_i;
            if (last_was_read && rd_other_device_i && gap_cnt == 2'h0) begin
                gap_cnt <= (rd_gap == 2'h2) ? 2'h2 : 2'h1;
                rd_hold_o <= 1'b1;
            end else if (gap_cnt > 2'h1) begin
                gap_cnt <= gap_cnt - 2'h1;
            end else begin
                gap_cnt <= 2'h0;
                rd_hold_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // phy update response
    // ----------------------------------------
    assign upd_sel = phyupd_resp[{phyupd_type_i, 1'b0} +: 2];

    // optional self-refresh, then stall and ack, exit
    always @(posedge clk_i) begin
        if (rst_i) begin
            upd_state <= UPD_IDLE;
            dfi_stall_o <= 1'b0;
            sref_req_o <= 1'b0;
            phyupd_ack_o <= 1'b0;
        end else begin
            case (upd_state)
                UPD_IDLE: begin
                    if (phyupd_req_i && DFI_PADS != 0) begin
                        if (upd_sel == `RESP_SREF_STALL) begin
                            sref_req_o <= 1'b1;
                            upd_state <= UPD_SREF;
                        end else if (upd_sel == `RESP_STALL) begin
                            dfi_stall_o <= 1'b1;
                            phyupd_ack_o <= 1'b1;
                            upd_state <= UPD_STALL;
                        end
                    end
                end
                UPD_SREF: begin
                    if (sref_done_i) begin
                        dfi_stall_o <= 1'b1;
                        phyupd_ack_o <= 1'b1;
                        upd_state <= UPD_STALL;
                    end
                end
                UPD_STALL: begin
                    if (!phyupd_req_i) begin
                        phyupd_ack_o <= 1'b0;
                        dfi_stall_o <= 1'b0;
                        upd_state <= sref_req_o ? UPD_EXIT : UPD_IDLE;
                    end
                end
                UPD_EXIT: begin
                    sref_req_o <= 1'b0;
                    upd_state <= UPD_IDLE;
                end
                default: upd_state <= UPD_IDLE;
            endcase
        end
    end
endmodule // dram_ctrl_timing_config_regs

// File: tb/timing_cfg_properties.sv
`timescale 1ns/10ps
module timing_cfg_properties (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire err_o,
    input wire rd_cmd_i,
    input wire dfi_rddata_en_o,
    input wire rd_hold_o,
    input wire phyupd_req_i,
    input wire sref_done_i,
    input wire phyupd_ack_o,
    input wire dfi_stall_o,
    input wire sref_req_o,
    input wire [1:0] clock_cfg_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_err_excl: assert property (!(ack_o && err_o))
        else $error("ack and err together");

    // ----------------------------------------
    // read path timing and clocking scheme
    // ----------------------------------------
    a_rden_bound: assert property (rd_cmd_i |-> ##[1:17] dfi_rddata_en_o)
        else $error("read data enable missing after read");
    a_gap_max: assert property (rd_hold_o ##1 rd_hold_o |=> !rd_hold_o)
        else $error("read gap longer than two cycles");
    a_clock_legal: assert property (clock_cfg_o != 2'h2)
        else $error("reserved clocking scheme in use");

    // ----------------------------------------
    // update handshake
    // ----------------------------------------
    a_stall_holds: assert property (dfi_stall_o && phyupd_req_i |=> dfi_stall_o)
        else $error("stall dropped while update pending");
    a_ack_stall: assert property (phyupd_ack_o |-> dfi_stall_o)
        else $error("update ack without stall");
    a_sref_first: assert property ($rose(dfi_stall_o) && sref_req_o |-> $past(sref_done_i))
        else $error("stall before self-refresh reached");
    a_sref_exit: assert property ($fell(dfi_stall_o) && sref_req_o |=> !sref_req_o)
        else $error("self-refresh exit late");

    // main scenarios seen
    c_ack: cover property (ack_o);
    c_sref_stall: cover property (sref_req_o && dfi_stall_o);
    c_gap_two: cover property (rd_hold_o ##1 rd_hold_o);
endmodule // timing_cfg_properties

// File: tb/phy_side_model.sv
`timescale 1ns/10ps
module phy_side_model (
    input wire clk_i,
    input wire rst_i,
    input wire sref_req_i,
    input wire dfi_stall_i,
    input wire phyupd_ack_i,
    output reg phyupd_req_o,
    output reg [1:0] phyupd_type_o,
    output reg sref_done_o
);
    reg [3:0] sr_cnt;
    reg [3:0] lat;
    initial begin
        phyupd_req_o = 1'b0;
        phyupd_type_o = 2'h0;
        sref_done_o = 1'b0;
        sr_cnt = 4'h0;
        lat = 4'h1;
    end
    // memories reach self-refresh lat+1 cycles after the request
    always @(posedge clk_i) begin
        sr_cnt <= (rst_i || !sref_req_i) ? 4'h0 : sr_cnt + {3'h0, sr_cnt != 4'hf};
        sref_done_o <= !rst_i && sref_req_i && (sr_cnt >= lat);
    end
    // one update request, held three cycles past the acknowledge, or past 40 cycles without one
    task update(input [1:0] t, input [3:0] l, output ok, output sref);
        integer i;
        begin
            lat = l;
            ok = 1'b0;
            sref = 1'b0;
            @(posedge clk_i);
            phyupd_req_o <= 1'b1;
            phyupd_type_o <= t;
            for (i = 0; i < 40 && !ok; i = i + 1) begin
                @(posedge clk_i);
                sref = sref | (sref_req_i === 1'b1);
                ok = (phyupd_ack_i === 1'b1);
            end
            repeat (3) @(posedge clk_i);
            phyupd_req_o <= 1'b0;
            phyupd_type_o <= ~t;
            repeat (10) @(posedge clk_i);
        end
    endtask
endmodule // phy_side_model

// File: tb/dram_ctrl_timing_config_regs_tb_top.sv
`timescale 1ns/10ps
module dram_ctrl_timing_config_regs_tb_top;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    reg [3:0] adr_i = 0;
    reg [3:0] sel_i = 4'hf;
    reg [31:0] dat_i = 0;
    reg same_clock_strap_i = 1, bus_faster_strap_i = 1, cke_init_strap_i = 1;
    reg dqm_init_strap_i = 0, mem_reset_release_i = 0, rd_cmd_i = 0, rd_other_device_i = 0;
    wire [31:0] dat_o;
    wire ack_o, err_o, phyupd_req_i, sref_done_i, dfi_rddata_en_o, rd_hold_o;
    wire phyupd_ack_o, dfi_stall_o, sref_req_o, cke_o, dqm_o;
    wire l_err, l_cke, l_dqm;
    wire [1:0] phyupd_type_i, clock_cfg_o;
    wire [9:0] prescale_o;
    wire [2:0] max_refs_o;
    integer err_count = 0, comparisons = 0, i, k;
    reg [31:0] q;
    reg e, le, ok, sr;

    dram_ctrl_timing_config_regs #(.DFI_PADS(1)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .same_clock_strap_i, .bus_faster_strap_i,
        .cke_init_strap_i, .dqm_init_strap_i, .mem_reset_release_i, .rd_cmd_i,
        .rd_other_device_i, .phyupd_req_i, .phyupd_type_i, .sref_done_i, .dfi_rddata_en_o,
        .rd_hold_o, .phyupd_ack_o, .dfi_stall_o, .sref_req_o, .cke_o, .dqm_o, .clock_cfg_o,
        .prescale_o, .max_refs_o);
    // legacy pad build on the same stimulus, for the init levels and absent registers
    dram_ctrl_timing_config_regs #(.DFI_PADS(0)) dut_legacy (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o(), .ack_o(), .err_o(l_err), .same_clock_strap_i,
        .bus_faster_strap_i, .cke_init_strap_i, .dqm_init_strap_i, .mem_reset_release_i,
        .rd_cmd_i, .rd_other_device_i, .phyupd_req_i, .phyupd_type_i, .sref_done_i,
        .dfi_rddata_en_o(), .rd_hold_o(), .phyupd_ack_o(), .dfi_stall_o(), .sref_req_o(),
        .cke_o(l_cke), .dqm_o(l_dqm), .clock_cfg_o(), .prescale_o(), .max_refs_o());
    phy_side_model u_phy (.clk_i(clk_i), .rst_i(rst_i), .sref_req_i(sref_req_o),
        .dfi_stall_i(dfi_stall_o), .phyupd_ack_i(phyupd_ack_o), .phyupd_req_o(phyupd_req_i),
        .phyupd_type_o(phyupd_type_i), .sref_done_o(sref_done_i));

    // clock, 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one classic bus cycle, held until ack or err
    task wb(input w, input [3:0] a, input [31:0] d);
        reg done;
        begin
            @(posedge clk_i);
            cyc_i <= 1;
            stb_i <= 1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            done = 0;
            for (i = 0; i < 20 && !done; i = i + 1) begin
                @(posedge clk_i);
                done = (ack_o === 1'b1) || (err_o === 1'b1);
                q = dat_o;
                e = (err_o === 1'b1);
                le = (l_err === 1'b1);
            end
            if (!done) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t bus timeout", $time);
                test_done;
            end
            cyc_i <= 0;
            stb_i <= 0;
            #1;
        end
    endtask
    task rd_chk(input [3:0] a, input [31:0] x);
        begin
            wb(0, a, 0);
            chk(q, x);
        end
    endtask

    task t_reset_vals;
        begin
            #1;
            chk(clock_cfg_o, 3);
            chk({l_cke, l_dqm, cke_o, dqm_o}, 4'h8);
            rd_chk(0, 32'hd);
            rd_chk(1, 32'h9);
            rd_chk(3, 32'h2);
            rd_chk(4, 32'h1);
            wb(0, 4'h7, 0);
            chk(e, 1);
            wb(0, 3, 0);
            chk({e, le}, 2'h1);
            $display("reset values done");
        end
    endtask
    task t_cfg3;
        begin
            wb(1, 1, 32'h1fff);
            rd_chk(1, 32'h1fff);
            chk(prescale_o, 10'h3ff);
            chk(max_refs_o, 7);
            wb(1, 1, 32'h1);
            chk({prescale_o, max_refs_o}, 13'h1);
            $display("config three done");
        end
    endtask
    task t_clock;
        begin
            wb(1, 0, 32'h2);
            @(posedge clk_i) mem_reset_release_i <= 1;
            @(posedge clk_i) mem_reset_release_i <= 0;
            #1;
            chk({l_cke, l_dqm, cke_o, dqm_o}, 4'h4);
            wb(1, 0, 32'h1);
            chk(clock_cfg_o, 0);
            wb(1, 0, 32'h5);
            chk(clock_cfg_o, 1);
            wb(1, 0, 32'hd);
            chk(clock_cfg_o, 3);
            wb(1, 0, 32'h9);
            chk(clock_cfg_o, 3);
            $display("clock scheme done");
        end
    endtask
    task t_lock;
        begin
            wb(1, 5, 32'h1);
            wb(1, 4, 32'h2);
            rd_chk(4, 32'h0);
            wb(1, 5, 32'h0);
            rd_chk(4, 32'h1);
            wb(1, 5, 32'h2);
            wb(1, 4, 32'h2);
            rd_chk(4, 32'h2);
            wb(1, 4, 32'h1);
            wb(1, 5, 32'h0);
            $display("state lock done");
        end
    endtask
    // read pulse, then count cycles to the enable
    task t_rden;
        integer d;
        begin
            for (d = 2; d < 10; d = d + 3) begin
                wb(1, 3, d); // cas latency 3: delay kept within 2 to 9
                @(posedge clk_i) rd_cmd_i <= 1;
                @(posedge clk_i) rd_cmd_i <= 0;
                k = 0;
                #1;
                while (dfi_rddata_en_o !== 1'b1 && k < 30) begin
                    @(posedge clk_i);
                    #1;
                    k = k + 1;
                end
                chk(k, d + 1);
                if (k == 30) test_done;
                repeat (20) @(posedge clk_i);
            end
            $display("read enable delay done");
        end
    endtask
    task t_gap;
        integer g;
        begin
            for (g = 1; g < 3; g = g + 1) begin
                wb(1, 4, g); // one idle cycle, then two for low-power parts
                @(posedge clk_i) rd_cmd_i <= 1;
                @(posedge clk_i) rd_cmd_i <= 0;
                rd_other_device_i <= 1;
                @(posedge clk_i) rd_other_device_i <= 0;
                k = 0;
                repeat (8) begin
                    #1 k = k + rd_hold_o;
                    @(posedge clk_i);
                end
                chk(k, g);
                repeat (20) @(posedge clk_i);
            end
            wb(1, 4, 32'h1);
            $display("read gap done");
        end
    endtask
    // selectors: type0 stall, type1 self-refresh, type2 reserved, type3 stall
    task t_update;
        integer t;
        begin
            wb(1, 2, 32'h61);
            rd_chk(2, 32'h61);
            for (t = 0; t < 4; t = t + 1) begin
                u_phy.update(t[1:0], (t == 1) ? 4'h6 : 4'h1, ok, sr);
                chk({ok, sr}, {t != 2, t == 1});
            end
            $display("update response done");
        end
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i) mem_reset_release_i <= 1;
        @(posedge clk_i) mem_reset_release_i <= 0;
        t_reset_vals;
        t_cfg3;
        t_clock;
        t_lock;
        t_rden;
        t_gap;
        t_update;
        test_done;
    end
endmodule // dram_ctrl_timing_config_regs_tb_top

bind dram_ctrl_timing_config_regs timing_cfg_properties u_props (.clk_i, .rst_i, .cyc_i,
    .stb_i, .ack_o, .err_o, .rd_cmd_i, .dfi_rddata_en_o, .rd_hold_o, .phyupd_req_i,
    .sref_done_i, .phyupd_ack_o, .dfi_stall_o, .sref_req_o, .clock_cfg_o);
